/* File: hdl/io_process_data_diag_sync.sv */
// process data mapping, emergency messages and I/O synchronisation of the I/O node
// Operation
// - outputs 1-4 from byte bits 0-3
// - status word bits 0-5 diagnostics, rest reserved
// - emergency message: code, register, five diag bytes
// - emergency messages sent unprompted, never confirmed
// - supply codes 3001-3005, temperature 4001
// - clearing sends code 0000, bit cleared
// - buffer event or sync pulse update modes
// - buffer event mode after reset, free running
// - outputs applied after output delay from pulse
// - inputs sampled after input delay from pulse
// - restore flag on write 1 to 2f00
// - connection timeout forces configured safe outputs
// - ready indicator green, steady or flashing
// - multi-byte values least significant byte first
// - firmware arrives over mailbox file transfer
module io_process_data_diag_sync #(
	parameter int LED_HALF_CYCLES = io_diag_pkg::LED_HALF_CYC
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// output process image from the buffer manager
	input wire logic i_buffer_manager_event,
	input wire logic [io_diag_pkg::PROC_BYTE_W-1:0] i_output_process_image,
	// input pins and diagnostic pins (asynchronous)
	input wire logic [io_diag_pkg::IN_CH-1:0] i_din,
	input wire io_diag_pkg::io_diag_t i_io_diag,
	input wire io_diag_pkg::emcy_fault_t i_emcy_fault,
	input wire logic i_time_sync_pulse,
	// mode, restart and network supervision
	input wire logic i_sync_mode_sel,
	input wire logic i_net_restart,
	input wire logic i_conn_timeout,
	input wire logic [io_diag_pkg::OUT_CH-1:0] i_safe_state,
	// configuration object write
	input wire logic i_obj_write,
	input wire logic [15:0] i_obj_index,
	input wire logic [7:0] i_obj_data,
	// mailbox file transfer bytes
	input wire logic i_file_xfer_start,
	input wire logic i_file_xfer_valid,
	input wire logic [7:0] i_file_xfer_byte,
	// boot and bus status
	input wire logic i_boot_done,
	input wire logic i_bus_flash,
	// emergency byte stream
	input wire logic i_emcy_ready,
	output logic o_emcy_valid,
	output logic [7:0] o_emcy_byte,
	output logic o_emcy_last,
	// process outputs and input image
	output logic [io_diag_pkg::OUT_CH-1:0] o_dout,
	output logic [io_diag_pkg::IN_CH-1:0] o_input_process_image,
	output logic [io_diag_pkg::STATUS_W-1:0] o_status_word,
	// status
	output logic o_mode_time_sync,
	output logic o_safe_active,
	output logic o_factory_restore_req,
	output logic o_ready_led_green,
	// firmware store
	output logic o_fw_wr_en,
	output logic [io_diag_pkg::FW_ADDR_W-1:0] o_fw_addr,
	output logic [7:0] o_fw_data
);
	import io_diag_pkg::*;

	// ****************************************************************
	// helper functions
	// ****************************************************************

	// lowest set bit of a fault vector
	function automatic logic [FAULT_IDX_W-1:0] first_set(input logic [NUM_FAULTS-1:0] v);
		logic [FAULT_IDX_W-1:0] r;
		r = '0;
		for (int k = NUM_FAULTS - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = FAULT_IDX_W'(k);
			end
		end
		return r;
	endfunction : first_set

	// error register from the flags that are active now
	function automatic logic [7:0] err_reg_of(input logic [NUM_FAULTS-1:0] f);
		logic [7:0] r;
		r = '0;
		r[ERR_BIT_SUPPLY] = |f[NUM_FAULTS-2:0];
		r[ERR_BIT_TEMP] = f[FAULT_TEMP_IDX];
		return r;
	endfunction : err_reg_of

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	localparam int PIN_W = IN_CH + NUM_DIAG + NUM_FAULTS + 1;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s [SYNC_STAGES];
	assign pin_raw = {i_time_sync_pulse, i_emcy_fault, i_io_diag, i_din};

	genvar g;
	generate
		for (g = 0; g < SYNC_STAGES; g++) begin : g_sync
			always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pin_s[g] <= '0;
				end else begin
					pin_s[g] <= (g == 0) ? pin_raw : pin_s[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate

	logic [IN_CH-1:0] din_s;
	logic [NUM_DIAG-1:0] diag_s;
	logic [NUM_FAULTS-1:0] fault_s;
	logic tsync_s;
	assign {tsync_s, fault_s, diag_s, din_s} = pin_s[SYNC_STAGES-1];

	// ****************************************************************
	// mode, pulse timing and safe state
	// ****************************************************************
	sync_mode_t mode_q;
	logic tsync_prev_q, tsync_edge;
	logic out_run_q, in_run_q;
	logic [DLY_W-1:0] out_cnt_q, in_cnt_q;
	logic out_fire, in_fire, safe_q;

	assign tsync_edge = tsync_s & ~tsync_prev_q & (mode_q == MODE_TIME_SYNC);
	assign out_fire = out_run_q & (out_cnt_q == '0);
	assign in_fire = in_run_q & (in_cnt_q == '0);

	// selected mode only becomes active on a network restart
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= MODE_BUF_EVENT;
			tsync_prev_q <= 1'b0;
		end else begin
			if (i_net_restart) begin
				mode_q <= i_sync_mode_sel ? MODE_TIME_SYNC : MODE_BUF_EVENT;
			end
			tsync_prev_q <= tsync_s;
		end
	end

	// fixed delay counters restarted by each rising pulse edge in sync pulse mode
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_run_q <= 1'b0;
			in_run_q <= 1'b0;
			out_cnt_q <= '0;
			in_cnt_q <= '0;
		end else if (tsync_edge) begin
			out_run_q <= 1'b1;
			in_run_q <= 1'b1;
			out_cnt_q <= DLY_W'(OUT_DELAY_CYC - 1);
			in_cnt_q <= DLY_W'(IN_DELAY_CYC - 1);
		end else begin
			out_run_q <= out_run_q & ~out_fire;
			in_run_q <= in_run_q & ~in_fire;
			out_cnt_q <= (out_run_q && !out_fire) ? out_cnt_q - 1'b1 : out_cnt_q;
			in_cnt_q <= (in_run_q && !in_fire) ? in_cnt_q - 1'b1 : in_cnt_q;
		end
	end

	// timeout latches until restart; a timeout in the restart cycle still wins
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			safe_q <= 1'b0;
		end else begin
			safe_q <= i_conn_timeout | (safe_q & ~i_net_restart);
		end
	end

	// ****************************************************************
	// process data
	// ****************************************************************
	logic [OUT_CH-1:0] stage_q, dout_q;
	logic [IN_CH-1:0] in_img_q;
	logic [NUM_DIAG-1:0] status_q;
	logic out_apply, in_sample;

	// buffer mode runs freely; pulse mode waits for the delay counters
	assign out_apply = (mode_q == MODE_BUF_EVENT) ? i_buffer_manager_event : out_fire;
	assign in_sample = (mode_q == MODE_BUF_EVENT) | in_fire;

	// upper four bits of the output byte are never looked at
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage_q <= '0;
			dout_q <= '0;
		end else begin
			if (i_buffer_manager_event) begin
				stage_q <= i_output_process_image[OUT_CH-1:0];
			end
			if (safe_q || i_conn_timeout) begin
				dout_q <= i_safe_state;
			end else if (out_apply) begin
				dout_q <= (mode_q == MODE_BUF_EVENT) ?
					i_output_process_image[OUT_CH-1:0] : stage_q;
			end
		end
	end

	// input image and diagnostics taken together so they stay consistent
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			in_img_q <= '0;
			status_q <= '0;
		end else if (in_sample) begin
			in_img_q <= din_s;
			status_q <= diag_s;
		end
	end

	assign o_dout = dout_q;
	assign o_input_process_image = in_img_q;
	assign o_status_word = {(STATUS_W - NUM_DIAG)'(0), status_q};
	assign o_mode_time_sync = (mode_q == MODE_TIME_SYNC);
	assign o_safe_active = safe_q;

	// ****************************************************************
	// emergency messages
	// ****************************************************************
	logic [NUM_FAULTS-1:0] fault_q, rise, fall, pend_rise_q, pend_fall_q, clr;
	logic [FAULT_IDX_W-1:0] sel_idx;
	logic sel_is_rise, msg_valid, msg_ready;
	emcy_msg_t msg;

	// a flag that flickers while pending still yields one rise and one fall
	assign rise = fault_s & ~fault_q;
	assign fall = ~fault_s & fault_q;
	assign sel_is_rise = |pend_rise_q;
	assign sel_idx = sel_is_rise ? first_set(pend_rise_q) : first_set(pend_fall_q);
	assign msg_valid = |pend_rise_q | |pend_fall_q;
	assign clr = (msg_valid & msg_ready) ? (NUM_FAULTS'(1) << sel_idx) : '0;

	// message fields; the error register follows the flags as they now stand
	assign msg.code = !sel_is_rise ? EMCY_CODE_RESET :
		(sel_idx == FAULT_TEMP_IDX) ? EMCY_CODE_TEMP :
		EMCY_CODE_SUPPLY_FIRST + 16'(sel_idx);
	assign msg.err_reg = err_reg_of(fault_s);
	assign msg.diag = {DIAG_ZERO, DIAG_ZERO, DIAG_ZERO,
		8'(sel_idx) + 8'h01, DIAG_ZERO};

	// edge pending bits: a new edge in the taking cycle wins over the clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault_q <= '0;
			pend_rise_q <= '0;
			pend_fall_q <= '0;
		end else begin
			fault_q <= fault_s;
			pend_rise_q <= rise | (pend_rise_q & ~(sel_is_rise ? clr : '0));
			pend_fall_q <= fall | (pend_fall_q & ~(sel_is_rise ? '0 : clr));
		end
	end

	emcy_serializer u_emcy_serializer (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_msg_valid(msg_valid),
		.i_msg(msg),
		.o_msg_ready(msg_ready),
		.o_byte_valid(o_emcy_valid),
		.o_byte(o_emcy_byte),
		.o_byte_last(o_emcy_last),
		.i_byte_ready(i_emcy_ready)
	);

	// ****************************************************************
	// restore request, ready indicator, firmware bytes
	// ****************************************************************
	logic restore_q, led_q, blink_q;
	logic [LED_CNT_W-1:0] blink_cnt_q;
	logic blink_wrap;
	logic fw_en_q;
	logic [FW_ADDR_W-1:0] fw_addr_q, fw_next_q;
	logic [7:0] fw_data_q;

	assign blink_wrap = (blink_cnt_q == LED_CNT_W'(LED_HALF_CYCLES - 1));

	// flag held until the next power-on reset acts on it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			restore_q <= 1'b0;
		end else if (i_obj_write && i_obj_index == OBJ_RESTORE_IDX
				&& i_obj_data == OBJ_RESTORE_VAL) begin
			restore_q <= 1'b1;
		end
	end

	// indicator stays dark until boot completes
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
			led_q <= 1'b0;
		end else begin
			blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + 1'b1;
			blink_q <= blink_q ^ blink_wrap;
			led_q <= i_boot_done & (~i_bus_flash | blink_q);
		end
	end

	// file bytes land at rising addresses, so byte order is kept as sent
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fw_en_q <= 1'b0;
			fw_addr_q <= '0;
			fw_next_q <= '0;
			fw_data_q <= '0;
		end else begin
			fw_en_q <= i_file_xfer_valid;
			fw_data_q <= i_file_xfer_byte;
			if (i_file_xfer_start) begin
				fw_next_q <= '0;
			end else if (i_file_xfer_valid) begin
				fw_addr_q <= fw_next_q;
				fw_next_q <= fw_next_q + 1'b1;
			end
		end
	end

	assign o_factory_restore_req = restore_q;
	assign o_ready_led_green = led_q;
	assign o_fw_wr_en = fw_en_q;
	assign o_fw_addr = fw_addr_q;
	assign o_fw_data = fw_data_q;

endmodule : io_process_data_diag_sync

/* File: hdl/io_diag_pkg.sv */
// package: constants, types and layouts shared by the process data, diagnostic and sync logic
package io_diag_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int OUT_DELAY_NS = 2000;
	localparam int IN_DELAY_NS = 1000;
	localparam int OUT_DELAY_CYC = (OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IN_DELAY_CYC = (IN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W = 8;
	localparam int LED_HALF_MS = 250;
	localparam int LED_HALF_CYC = (LED_HALF_MS * 1000000) / CLK_PERIOD_NS;
	localparam int LED_CNT_W = 25;

	// ****************************************************************
	// widths and field positions
	// ****************************************************************
	localparam int OUT_CH = 4;
	localparam int IN_CH = 8;
	localparam int PROC_BYTE_W = 8;
	localparam int STATUS_W = 32;
	localparam int NUM_DIAG = 6;
	localparam int NUM_FAULTS = 6;
	localparam int FAULT_IDX_W = 3;
	localparam logic [FAULT_IDX_W-1:0] FAULT_TEMP_IDX = 3'h5;
	localparam int MSG_BYTES = 8;
	localparam int BYTE_IDX_W = 3;
	localparam int FW_ADDR_W = 24;
	localparam int SYNC_STAGES = 2;

	// ****************************************************************
	// emergency message contents
	// ****************************************************************
	localparam logic [15:0] EMCY_CODE_RESET = 16'h0000;
	localparam logic [15:0] EMCY_CODE_SUPPLY_FIRST = 16'h3001;
	localparam logic [15:0] EMCY_CODE_TEMP = 16'h4001;
	localparam int ERR_BIT_SUPPLY = 2;
	localparam int ERR_BIT_TEMP = 4;
	localparam logic [7:0] DIAG_ZERO = 8'h00;

	// ****************************************************************
	// configuration object
	// ****************************************************************
	localparam logic [15:0] OBJ_RESTORE_IDX = 16'h2f00;
	localparam logic [7:0] OBJ_RESTORE_VAL = 8'h01;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic {MODE_BUF_EVENT = 1'b0, MODE_TIME_SYNC = 1'b1} sync_mode_t;
	typedef enum logic {SER_IDLE = 1'b0, SER_SEND = 1'b1} ser_state_t;

	// input status word low bits, bit 0 first from the bottom
	typedef struct packed {
		logic ls_undervolt;
		logic ls_overload;
		logic act_undervolt;
		logic act_short;
		logic out_overload;
		logic out_short;
	} io_diag_t;

	// emergency fault flags, index i gives diagnostic byte n = i + 1
	typedef struct packed {
		logic over_temp;
		logic act_undervolt;
		logic act_surge;
		logic sup_undervolt;
		logic sup_surge;
		logic sup_overcurrent;
	} emcy_fault_t;

	// lowest bits go out first on the wire
	typedef struct packed {
		logic [39:0] diag;
		logic [7:0] err_reg;
		logic [15:0] code;
	} emcy_msg_t;

endpackage : io_diag_pkg

/* File: hdl/emcy_serializer.sv */
// emergency message serializer: one 8-byte message out as bytes, low byte first
module emcy_serializer (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// message side
	input wire logic i_msg_valid,
	input wire io_diag_pkg::emcy_msg_t i_msg,
	output logic o_msg_ready,
	// byte side
	output logic o_byte_valid,
	output logic [7:0] o_byte,
	output logic o_byte_last,
	input wire logic i_byte_ready
);
	import io_diag_pkg::*;

	ser_state_t state_q, state_d;
	logic [MSG_BYTES*8-1:0] shift_q, shift_d;
	logic [BYTE_IDX_W-1:0] idx_q, idx_d;
	logic take_msg, take_byte, at_last;

	// handshakes
	assign o_msg_ready = (state_q == SER_IDLE);
	assign take_msg = i_msg_valid & o_msg_ready;
	assign o_byte_valid = (state_q == SER_SEND);
	assign take_byte = o_byte_valid & i_byte_ready;
	assign at_last = (idx_q == BYTE_IDX_W'(MSG_BYTES - 1));
	assign o_byte_last = o_byte_valid & at_last;
	assign o_byte = shift_q[7:0]; // low byte first

	// next state: load whole message, then shift right one byte per accepted byte
	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		idx_d = idx_q;
		unique case (state_q)
			SER_IDLE: begin
				if (take_msg) begin
					state_d = SER_SEND;
					shift_d = i_msg; // code, register, 5 diag bytes
					idx_d = '0;
				end
			end
			SER_SEND: begin
				if (take_byte) begin
					shift_d = {8'h00, shift_q[MSG_BYTES*8-1:8]};
					idx_d = idx_q + 1'b1;
					if (at_last) begin
						state_d = SER_IDLE;
					end
				end
			end
		endcase
	end

	// no acknowledge comes back from the master, so a message ends at its last byte
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= SER_IDLE;
			shift_q <= '0;
			idx_q <= '0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			idx_q <= idx_d;
		end
	end

endmodule : emcy_serializer

/* File: bench/io_pdds_props.sv */
// port checker for the process data, diagnostic and sync block
module io_pdds_props (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// master side requests
	input wire logic i_buffer_manager_event,
	input wire logic [io_diag_pkg::PROC_BYTE_W-1:0] i_output_process_image,
	input wire logic i_net_restart,
	input wire logic i_conn_timeout,
	input wire logic [io_diag_pkg::OUT_CH-1:0] i_safe_state,
	input wire logic i_obj_write,
	input wire logic [15:0] i_obj_index,
	input wire logic [7:0] i_obj_data,
	input wire logic i_file_xfer_valid,
	input wire logic [7:0] i_file_xfer_byte,
	input wire logic i_boot_done,
	input wire logic i_bus_flash,
	input wire logic i_emcy_ready,
	// block outputs
	input wire logic o_emcy_valid,
	input wire logic [7:0] o_emcy_byte,
	input wire logic o_emcy_last,
	input wire logic [io_diag_pkg::OUT_CH-1:0] o_dout,
	input wire logic [io_diag_pkg::STATUS_W-1:0] o_status_word,
	input wire logic o_mode_time_sync,
	input wire logic o_safe_active,
	input wire logic o_factory_restore_req,
	input wire logic o_ready_led_green,
	input wire logic o_fw_wr_en,
	input wire logic [7:0] o_fw_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import io_diag_pkg::*;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	// free-run mapping: upper nibble must never leak to the pins
	dout_map_a: assert property (
		i_buffer_manager_event && !o_mode_time_sync && !o_safe_active && !i_conn_timeout
		&& !i_net_restart |=> o_dout == $past(i_output_process_image[3:0]))
		else $error("output byte not mapped to outputs");
	status_rsvd_a: assert property (o_status_word[31:6] == 26'h0000000)
		else $error("reserved status bits set");
	emcy_hold_a: assert property (
		o_emcy_valid && !i_emcy_ready |=> o_emcy_valid && $stable(o_emcy_byte) && $stable(o_emcy_last))
		else $error("emergency byte dropped before accept");
	emcy_gap_a: assert property (o_emcy_valid && o_emcy_last && i_emcy_ready |=> !o_emcy_valid)
		else $error("no idle cycle after message");
	safe_out_a: assert property (
		i_conn_timeout |=> o_safe_active && o_dout == $past(i_safe_state))
		else $error("timeout did not force safe outputs");
	restore_set_a: assert property (
		i_obj_write && i_obj_index == 16'h2f00 && i_obj_data == 8'h01 |=> o_factory_restore_req)
		else $error("restore request not raised");
	restore_keep_a: assert property (o_factory_restore_req |=> o_factory_restore_req [*4])
		else $error("restore request lost");
	mode_hold_a: assert property (!i_net_restart |=> $stable(o_mode_time_sync))
		else $error("mode changed without restart");
	led_on_a: assert property (i_boot_done && !i_bus_flash |=> o_ready_led_green)
		else $error("ready indicator not steady on");
	fw_write_a: assert property (
		i_file_xfer_valid |=> o_fw_wr_en && o_fw_data == $past(i_file_xfer_byte))
		else $error("firmware byte not written");

	// main scenarios reached
	cover property (o_emcy_valid && o_emcy_last && i_emcy_ready);
	cover property (o_mode_time_sync && o_dout != $past(o_dout));
	cover property (o_safe_active && i_buffer_manager_event);
endmodule : io_pdds_props

/* File: bench/master_model.sv */
// master controller model: output byte, restart, and emergency byte sink
module master_model (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// consumer pace: 1 accepts every other cycle
	input wire logic i_slow,
	// towards the node
	output logic o_event,
	output logic [7:0] o_image,
	output logic o_restart,
	output logic o_emcy_ready,
	// emergency bytes from the node
	input wire logic i_emcy_valid,
	input wire logic [7:0] i_emcy_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	logic tog = 1'b0;

	initial begin
		o_event = 1'b0;
		o_image = 8'h00;
		o_restart = 1'b0;
	end

	// ready pattern changes off the sampling edge
	always @(negedge i_sys_clk) begin
		tog <= ~tog;
		o_emcy_ready <= i_rst_n && (!i_slow || tog);
	end

	// bytes kept in arrival order, low byte first; nothing is confirmed back
	always @(posedge i_sys_clk) begin
		if (i_emcy_valid && o_emcy_ready) begin
			rx_q.push_back(i_emcy_byte);
		end
	end

	// one cyclic frame; the lane shows garbage once the event is gone
	task automatic send_out(input logic [7:0] b);
		@(negedge i_sys_clk);
		o_event = 1'b1;
		o_image = b;
		@(negedge i_sys_clk);
		o_event = 1'b0;
		o_image = ~b;
	endtask : send_out

	// restart through the network applies the selected mode
	task automatic restart();
		@(negedge i_sys_clk);
		o_restart = 1'b1;
		@(negedge i_sys_clk);
		o_restart = 1'b0;
	endtask : restart
endmodule : master_model

/* File: bench/tb_io_process_data_diag_sync.sv */
// self-checking bench for the process data, diagnostic and sync block
module tb_io_process_data_diag_sync;
	timeunit 1ns;
	timeprecision 1ps;
	import io_diag_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, ev, rs, rdy, sel = 1'b0, tmo = 1'b0;
	logic ow = 1'b0, fxs = 1'b0, fxv = 1'b0, boot = 1'b0, flash = 1'b0, pulse = 1'b0;
	logic [7:0] img, din = 8'h00, odat = 8'h00, fxb = 8'h00, eb, pimg, fwd;
	logic [15:0] oidx = 16'h0000;
	logic [3:0] safe = 4'h0, dout;
	io_diag_t diag = '0;
	emcy_fault_t flt = '0;
	logic evld, elast, msync, sact, rreq, led, fwe;
	logic [31:0] sw;
	logic [23:0] fwa;
	int errors = 0, check_count = 0, cyc = 0;

	always #5 clk = ~clk;

	io_process_data_diag_sync #(.LED_HALF_CYCLES(8)) DUT (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_buffer_manager_event(ev),
		.i_output_process_image(img), .i_din(din), .i_io_diag(diag), .i_emcy_fault(flt),
		.i_time_sync_pulse(pulse), .i_sync_mode_sel(sel), .i_net_restart(rs),
		.i_conn_timeout(tmo), .i_safe_state(safe), .i_obj_write(ow), .i_obj_index(oidx),
		.i_obj_data(odat), .i_file_xfer_start(fxs), .i_file_xfer_valid(fxv),
		.i_file_xfer_byte(fxb), .i_boot_done(boot), .i_bus_flash(flash), .i_emcy_ready(rdy),
		.o_emcy_valid(evld), .o_emcy_byte(eb), .o_emcy_last(elast), .o_dout(dout),
		.o_input_process_image(pimg), .o_status_word(sw), .o_mode_time_sync(msync),
		.o_safe_active(sact), .o_factory_restore_req(rreq), .o_ready_led_green(led),
		.o_fw_wr_en(fwe), .o_fw_addr(fwa), .o_fw_data(fwd));

	master_model mst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .o_event(ev),
		.o_image(img), .o_restart(rs), .o_emcy_ready(rdy), .i_emcy_valid(evld),
		.i_emcy_byte(eb));

	// ****************************************************************
	// checking and closing
	// ****************************************************************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// the whole run needs about 900 cycles; a hang ends here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			errors++;
			stop_test();
		end
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_out();
		chk(msync, 1'b0);
		mst.send_out(8'hfa);
		chk(dout, 4'ha);
		mst.send_out(8'h05);
		chk(dout, 4'h5);
	endtask : t_out

	task automatic t_status();
		din = 8'ha5;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			diag = io_diag_t'(6'h01 << i);
			repeat (4) @(negedge clk);
			chk(sw, 32'h1 << i);
		end
		chk(pimg, 8'ha5);
	endtask : t_status

	// one rise and one fall per flag; odd flags meet a stalling consumer
	task automatic t_emcy();
		logic [15:0] code;
		logic [7:0] e[8];
		int t;
		for (int i = 0; i < NUM_FAULTS; i++) begin
			slow = i[0];
			for (int k = 0; k < 2; k++) begin
				code = (i == 5) ? EMCY_CODE_TEMP : EMCY_CODE_SUPPLY_FIRST + 16'(i);
				code = k ? EMCY_CODE_RESET : code;
				e = '{code[7:0], code[15:8], 8'h00, 8'h00, 8'(i + 1), 8'h00, 8'h00, 8'h00};
				e[2] = k ? 8'h00 : ((i == 5) ? 8'h10 : 8'h04);
				@(negedge clk);
				flt = emcy_fault_t'((k == 0) ? 6'h01 << i : 6'h00);
				t = 0;
				while (mst.rx_q.size() < 8 && t < 200) begin
					@(negedge clk);
					t++;
				end
				repeat (30) @(negedge clk);
				chk(mst.rx_q.size(), 8);
				for (int j = 0; j < 8; j++) begin
					chk(mst.rx_q.pop_front(), e[j]);
				end
			end
		end
	endtask : t_emcy

	task automatic t_safe();
		safe = 4'h9;
		@(negedge clk);
		tmo = 1'b1;
		@(negedge clk);
		tmo = 1'b0;
		mst.send_out(8'h06);
		chk(sact, 1'b1);
		chk(dout, 4'h9);
		mst.restart();
		mst.send_out(8'h05);
		chk({sact, dout}, 5'h05);
	endtask : t_safe

	// pins are sampled and driven only after the fixed delays from the pulse
	task automatic t_sync();
		sel = 1'b1;
		mst.send_out(8'h03);
		chk(msync, 1'b0);
		mst.restart();
		chk(msync, 1'b1);
		mst.send_out(8'h0c);
		chk(dout, 4'h3);
		din = 8'h5a;
		pulse = 1'b1;
		@(negedge clk);
		pulse = 1'b0;
		repeat (IN_DELAY_CYC - 2) @(negedge clk);
		chk(pimg, 8'ha5);
		repeat (8) @(negedge clk);
		chk(pimg, 8'h5a);
		repeat (OUT_DELAY_CYC - 110) @(negedge clk);
		chk(dout, 4'h3);
		repeat (10) @(negedge clk);
		chk(dout, 4'hc);
	endtask : t_sync

	task automatic t_misc();
		logic [23:0] wr[3];
		int n;
		logic prev;
		wr = '{24'h2f0002, 24'h2f0101, 24'h2f0001};
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			ow = 1'b1;
			oidx = wr[i][23:8];
			odat = wr[i][7:0];
			@(negedge clk);
			ow = 1'b0;
			chk(rreq, i == 2);
		end
		fxs = 1'b1;
		@(negedge clk);
		fxs = 1'b0;
		for (int j = 0; j < 3; j++) begin
			fxv = 1'b1;
			fxb = 8'h30 + 8'(j);
			@(negedge clk);
			fxv = 1'b0;
			chk({fwe, fwa, fwd}, {1'b1, 24'(j), 8'h30 + 8'(j)});
			@(negedge clk);
		end
		boot = 1'b1;
		repeat (2) @(negedge clk);
		chk(led, 1'b1);
		flash = 1'b1;
		n = 0;
		for (int c = 0; c < 40; c++) begin
			@(negedge clk);
			if (c > 0 && led !== prev) begin
				n++;
			end
			prev = led;
		end
		chk(n inside {4, 5}, 1'b1);
	endtask : t_misc

	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({msync, dout, sw}, 37'h0);
		t_out();
		t_status();
		t_emcy();
		t_safe();
		t_sync();
		t_misc();
		stop_test();
	end
endmodule : tb_io_process_data_diag_sync

bind io_process_data_diag_sync io_pdds_props props (.*);
